// ### hdl/addr_ctl_pkg.sv
// shared constants and carrier types for the effective-address control block
package addr_ctl_pkg;
	localparam int PAGE_BITS = 10;
	localparam int PAGE_OFF_BITS = 14;
	localparam int SEG_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int CNT_BITS = 3;
	localparam logic [CNT_BITS-1:0] CNT_RESET = 3'h0;
	localparam logic [1:0] DPP_SEL_RESET = 2'h0;
	localparam logic [7:0] SEG_CODE_0 = 8'h00;
	localparam logic [7:0] SEG_CODE_1 = 8'h01;
	localparam int CODE_WIN_BITS = 15;
	localparam logic [1:0] MAP_DELAY = 2'h2;
	localparam logic [PAGE_BITS-1:0] DPP_RESET = 10'h000;

	typedef enum logic [2:0] {
		OVR_NONE = 3'h0,
		OVR_ATOMIC = 3'h1,
		OVR_PAGE = 3'h2,
		OVR_SEG = 3'h3,
		OVR_REDIR = 3'h4,
		OVR_PAGE_REDIR = 3'h5,
		OVR_SEG_REDIR = 3'h6
	} ovr_cmd_t;

	typedef struct packed {
		logic valid;
		ovr_cmd_t cmd;
		logic [CNT_BITS-1:0] count;
		logic [PAGE_BITS-1:0] number;
	} ovr_req_t;

	typedef struct packed {
		logic valid;
		logic is_data;
		logic short_mode;
		logic [15:0] offset;
	} acc_req_t;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic to_internal;
		logic to_ext_sfr;
	} acc_rsp_t;
endpackage : addr_ctl_pkg

// ### hdl/address_override_rom_map.sv
// effective-address control: overrides, extension counter and code area map
// Summary of operation
// - default address from page pointer plus offset
// - page override replaces page for 1-7 instrs
// - segment override uses 16-bit offset in segment
// - normal paging returns once count exhausted
// - all overrides block interrupts like atomic
// - redirect short accesses to extended function space
// - combined forms override and redirect together
// - nested override reloads counter with new count
// - no event channel service in locked idle
// - code area decodes full 32K window
// - code area in segment 0, 1 or off
// - boot source sampled just after reset release
// - reset maps code area at segment 0
// - seg1 select moves area, segment 0 external
// - vectors at zero external when moved
// - map change effective second instruction later
// - enable after external boot: current offset internal
// - disable after internal boot: hold until seg 0 jump
// - atomic locks 1-7, class B traps pass
// - multicycle instruction counts once
`timescale 1ns/1ns
module address_override_rom_map (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic boot_source_select_i,
	input wire addr_ctl_pkg::ovr_req_t ovr_req_i,
	input wire logic instr_done_i,
	input wire logic [1:0] dpp_sel_i,
	input wire logic dpp_wr_i,
	input wire logic [1:0] dpp_wr_sel_i,
	input wire logic [addr_ctl_pkg::PAGE_BITS-1:0] dpp_wr_data_i,
	input wire logic code_mem_enable_wr_i,
	input wire logic code_mem_enable_i,
	input wire logic code_area_seg1_select_wr_i,
	input wire logic code_area_seg1_select_i,
	input wire logic segment_jump_instr_i,
	input wire logic [addr_ctl_pkg::SEG_BITS-1:0] jump_seg_i,
	input wire logic idle_instr_i,
	input wire addr_ctl_pkg::acc_req_t acc_req_i,
	input wire logic [addr_ctl_pkg::ADDR_BITS-1:0] fetch_addr_i,
	output addr_ctl_pkg::acc_rsp_t acc_rsp_o,
	output logic fetch_internal_o,
	output logic irq_block_o,
	output logic class_a_trap_block_o,
	output logic pec_block_o,
	output logic code_mem_enabled_o,
	output logic code_area_seg1_o
);
	logic rst_meta;
	logic rst_n;
	logic boot_meta;
	logic boot_sync;
	logic boot_taken;
	logic [addr_ctl_pkg::PAGE_BITS-1:0] dpp [4];
	logic [addr_ctl_pkg::CNT_BITS-1:0] ext_count;
	logic page_ovr;
	logic seg_ovr;
	logic redir;
	logic [addr_ctl_pkg::PAGE_BITS-1:0] ovr_number;
	logic idle_locked;
	logic code_en;
	logic code_seg1;
	logic pend_en;
	logic pend_seg1;
	logic [1:0] map_wait;
	logic hold_fetch;
	logic in_lock;
	logic next_page_ovr;
	logic next_seg_ovr;
	logic next_redir;
	logic [addr_ctl_pkg::ADDR_BITS-1:0] data_addr;
	logic map_apply;

	// decide whether an address lands in the 32K code window
	function automatic logic in_code_area(input logic [23:0] a, input logic en,
			input logic seg1);
		logic [7:0] seg;
		seg = seg1 ? addr_ctl_pkg::SEG_CODE_1 : addr_ctl_pkg::SEG_CODE_0;
		in_code_area = en && a[23:16] == seg && !a[addr_ctl_pkg::CODE_WIN_BITS];
	endfunction : in_code_area

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_meta <= 1'b0;
			boot_sync <= 1'b0;
		end else begin
			boot_meta <= boot_source_select_i;
			boot_sync <= boot_meta;
		end
	end

	// lock open while the extension counter runs
	assign in_lock = ext_count != addr_ctl_pkg::CNT_RESET;

	// map change lands only on an instruction with no write beside it
	assign map_apply = boot_taken && map_wait == 2'h1 && instr_done_i &&
			!code_mem_enable_wr_i && !code_area_seg1_select_wr_i;

	// page pointer registers
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				dpp[i] <= addr_ctl_pkg::DPP_RESET;
			end
		end else if (dpp_wr_i) begin
			dpp[dpp_wr_sel_i] <= dpp_wr_data_i;
		end
	end

	always_comb begin
		next_page_ovr = page_ovr;
		next_seg_ovr = seg_ovr;
		next_redir = redir;
		unique case (ovr_req_i.cmd)
			addr_ctl_pkg::OVR_PAGE: begin
				next_page_ovr = 1'b1;
				next_seg_ovr = 1'b0;
				next_redir = 1'b0;
			end
			addr_ctl_pkg::OVR_SEG: begin
				next_page_ovr = 1'b0;
				next_seg_ovr = 1'b1;
				next_redir = 1'b0;
			end
			addr_ctl_pkg::OVR_REDIR: begin
				next_page_ovr = 1'b0;
				next_seg_ovr = 1'b0;
				next_redir = 1'b1;
			end
			addr_ctl_pkg::OVR_PAGE_REDIR: begin
				next_page_ovr = 1'b1;
				next_seg_ovr = 1'b0;
				next_redir = 1'b1;
			end
			addr_ctl_pkg::OVR_SEG_REDIR: begin
				next_page_ovr = 1'b0;
				next_seg_ovr = 1'b1;
				next_redir = 1'b1;
			end
			default: begin
				next_page_ovr = page_ovr;
				next_seg_ovr = seg_ovr;
				next_redir = redir;
			end
		endcase
	end

	// extension counter and override state
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_count <= addr_ctl_pkg::CNT_RESET;
			page_ovr <= 1'b0;
			seg_ovr <= 1'b0;
			redir <= 1'b0;
			ovr_number <= addr_ctl_pkg::DPP_RESET;
		end else if (ovr_req_i.valid && ovr_req_i.cmd != addr_ctl_pkg::OVR_NONE) begin
			ext_count <= ovr_req_i.count;
			if (ovr_req_i.count == addr_ctl_pkg::CNT_RESET) begin
				// zero count closes the lock at once
				page_ovr <= 1'b0;
				seg_ovr <= 1'b0;
				redir <= 1'b0;
			end else begin
				page_ovr <= next_page_ovr;
				seg_ovr <= next_seg_ovr;
				redir <= next_redir;
			end
			if (ovr_req_i.cmd != addr_ctl_pkg::OVR_ATOMIC &&
					ovr_req_i.cmd != addr_ctl_pkg::OVR_REDIR) begin
				ovr_number <= ovr_req_i.number;
			end
		end else if (instr_done_i && in_lock) begin
			ext_count <= ext_count - 3'h1;
			if (ext_count == 3'h1) begin
				page_ovr <= 1'b0;
				seg_ovr <= 1'b0;
				redir <= 1'b0;
			end
		end
	end

	assign irq_block_o = in_lock;
	// class A traps held off, class B passes
	assign class_a_trap_block_o = in_lock;

	// locked idle keeps event channel off
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			idle_locked <= 1'b0;
		end else if (idle_instr_i) begin
			idle_locked <= in_lock;
		end else if (ovr_req_i.valid || instr_done_i) begin
			idle_locked <= 1'b0;
		end
	end
	// idle as last locked instruction keeps the block
	assign pec_block_o = in_lock || idle_locked;

	// data address formation
	always_comb begin
		if (seg_ovr) begin
			data_addr = {ovr_number[7:0], acc_req_i.offset};
		end else if (page_ovr) begin
			data_addr = {ovr_number, acc_req_i.offset[13:0]};
		end else begin
			data_addr = {dpp[acc_req_i.offset[15:14]], acc_req_i.offset[13:0]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc_rsp_o <= '0;
		end else if (acc_req_i.valid) begin
			acc_rsp_o.addr <= data_addr;
			acc_rsp_o.to_internal <= in_code_area(data_addr, code_en, code_seg1);
			acc_rsp_o.to_ext_sfr <= redir && acc_req_i.short_mode;
		end
	end

	// code area map: boot strap then software writes, delayed
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			boot_taken <= 1'b0;
			code_en <= 1'b0;
			code_seg1 <= 1'b0;
			pend_en <= 1'b0;
			pend_seg1 <= 1'b0;
			map_wait <= 2'h0;
		end else if (!boot_taken) begin
			boot_taken <= 1'b1;
			code_en <= boot_sync;
			pend_en <= boot_sync;
		end else begin
			if (code_mem_enable_wr_i || code_area_seg1_select_wr_i) begin
				if (code_mem_enable_wr_i) begin
					pend_en <= code_mem_enable_i;
				end
				if (code_area_seg1_select_wr_i) begin
					pend_seg1 <= code_area_seg1_select_i;
				end
				map_wait <= addr_ctl_pkg::MAP_DELAY;
			end else if (map_wait != 2'h0 && instr_done_i) begin
				map_wait <= map_wait - 2'h1;
				if (map_wait == 2'h1) begin
					code_en <= pend_en;
					code_seg1 <= pend_seg1;
				end
			end
		end
	end

	// hold internal fetching until segment-0 jump
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_fetch <= 1'b0;
		end else if (code_en && map_apply && !pend_en) begin
			// set wins over a jump in the same cycle
			hold_fetch <= 1'b1;
		end else if (segment_jump_instr_i && jump_seg_i == addr_ctl_pkg::SEG_CODE_0) begin
			hold_fetch <= 1'b0;
		end
	end

	// hold keeps fetches on the old path
	// enabled area takes current offset
	assign fetch_internal_o = hold_fetch || in_code_area(fetch_addr_i, code_en, code_seg1);
	assign code_mem_enabled_o = code_en;
	assign code_area_seg1_o = code_seg1;
endmodule : address_override_rom_map

// ### tb/address_override_rom_map_tb_top.sv
// self-checking bench for the address control block
`timescale 1ns/1ns
module address_override_rom_map_tb_top;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	addr_ctl_pkg::ovr_req_t ovr = '0;
	addr_ctl_pkg::acc_req_t acc = '0;
	addr_ctl_pkg::acc_rsp_t rsp;
	logic done, fi, blk, trap, peripheral_event_channel, ena, s1o;
	logic dwr = 1'b0, ewr = 1'b0, en = 1'b0, swr = 1'b0, s1 = 1'b0, jmp = 1'b0, go = 1'b0;
	logic idl = 1'b0;
	// internal boot assumes a valid vector
	logic bs = 1'b1;
	logic [7:0] js = 8'h00;
	logic [9:0] dd = 10'h000;
	logic [23:0] fa = 24'h000000;
	logic [2:0] pn = 3'h0;
	int fail_count = 0, comparisons = 0, cycles = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	pipe_model pipe_model_i (.ref_clk_i, .start_i(go), .n_i(pn), .instr_done_o(done));
	address_override_rom_map address_override_rom_map_i (.ref_clk_i, .nrst_i,
		.boot_source_select_i(bs), .ovr_req_i(ovr), .instr_done_i(done),
		.dpp_sel_i(2'h0), .dpp_wr_i(dwr), .dpp_wr_sel_i(2'h1), .dpp_wr_data_i(dd),
		.code_mem_enable_wr_i(ewr), .code_mem_enable_i(en),
		.code_area_seg1_select_wr_i(swr), .code_area_seg1_select_i(s1),
		.segment_jump_instr_i(jmp), .jump_seg_i(js), .idle_instr_i(idl),
		.acc_req_i(acc), .fetch_addr_i(fa), .acc_rsp_o(rsp), .fetch_internal_o(fi),
		.irq_block_o(blk), .class_a_trap_block_o(trap), .pec_block_o(peripheral_event_channel),
		.code_mem_enabled_o(ena), .code_area_seg1_o(s1o));
	task automatic chk(input string w, input logic [25:0] e, input logic [25:0] g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", w, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic ov(input addr_ctl_pkg::ovr_cmd_t c, input logic [2:0] n, input logic [9:0] k);
		@(posedge ref_clk_i);
		ovr <= '{1'b1, c, n, k};
		@(posedge ref_clk_i);
		ovr.valid <= 1'b0;
		#1;
	endtask : ov
	task automatic ac(input logic [15:0] off, input logic sh);
		@(posedge ref_clk_i);
		acc <= '{1'b1, 1'b1, sh, off};
		@(posedge ref_clk_i);
		acc.valid <= 1'b0;
		#1;
	endtask : ac
	task automatic run(input logic [2:0] n);
		@(posedge ref_clk_i);
		go <= 1'b1;
		pn <= n;
		@(posedge ref_clk_i);
		go <= 1'b0;
		repeat (int'(n) + 1) @(posedge ref_clk_i);
		#1;
	endtask : run
	// remap writes carry no code accesses
	task automatic mw(input logic ew, input logic sw, input logic v);
		@(posedge ref_clk_i);
		ewr <= ew;
		swr <= sw;
		en <= v;
		s1 <= v;
		@(posedge ref_clk_i);
		ewr <= 1'b0;
		swr <= 1'b0;
	endtask : mw
	task automatic fk(input logic [23:0] a, input logic e);
		@(posedge ref_clk_i);
		fa <= a;
		#1;
		chk("fetch", {25'h0, e}, {25'h0, fi});
	endtask : fk
	task automatic dw(input logic [9:0] v);
		@(posedge ref_clk_i);
		dwr <= 1'b1;
		dd <= v;
		@(posedge ref_clk_i);
		dwr <= 1'b0;
	endtask : dw
	task automatic jp(input logic [7:0] s);
		@(posedge ref_clk_i);
		jmp <= 1'b1;
		js <= s;
		@(posedge ref_clk_i);
		jmp <= 1'b0;
	endtask : jp
	task automatic t_addr();
		dw(10'h005);
		ac(16'h4123, 1'b0);
		chk("pointer", {24'h014123, 2'b00}, rsp);
		ov(addr_ctl_pkg::OVR_PAGE, 3'h2, 10'h3a5);
		ac(16'h0012, 1'b0);
		chk("page", {24'he94012, 2'b00}, rsp);
		run(3'h2);
		ac(16'h4123, 1'b0);
		chk("back", {24'h014123, 2'b00}, rsp);
		ov(addr_ctl_pkg::OVR_SEG, 3'h1, 10'h00f);
		ac(16'hbeef, 1'b0);
		chk("segment", {24'h0fbeef, 2'b00}, rsp);
		run(3'h1);
	endtask : t_addr
	task automatic t_cmds();
		for (int c = 1; c < 7; c++) begin
			ov(addr_ctl_pkg::ovr_cmd_t'(c), 3'h1, 10'h000);
			chk("block", 26'h1, {25'h0, blk});
			chk("trap", 26'h1, {25'h0, trap});
			chk("event", 26'h1, {25'h0, peripheral_event_channel});
			ac(16'h0010, 1'b1);
			chk("redirect", {24'h000010, 1'b1, c > 3}, rsp);
			run(3'h1);
			chk("release", 26'h0, {25'h0, blk});
			chk("trap release", 26'h0, {25'h0, trap});
		end
	endtask : t_cmds
	task automatic t_nest();
		ov(addr_ctl_pkg::OVR_ATOMIC, 3'h2, 10'h000);
		run(3'h1);
		ov(addr_ctl_pkg::OVR_ATOMIC, 3'h3, 10'h000);
		run(3'h2);
		chk("nest", 26'h1, {25'h0, blk});
		run(3'h1);
		chk("nest end", 26'h0, {25'h0, blk});
	endtask : t_nest
	task automatic t_idle();
		ov(addr_ctl_pkg::OVR_ATOMIC, 3'h1, 10'h000);
		@(posedge ref_clk_i);
		go <= 1'b1;
		pn <= 3'h1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		idl <= 1'b1;
		@(posedge ref_clk_i);
		idl <= 1'b0;
		#1;
		chk("idle block", 26'h1, {25'h0, peripheral_event_channel});
		chk("idle lock end", 26'h0, {25'h0, blk});
		run(3'h1);
		chk("idle wake", 26'h0, {25'h0, peripheral_event_channel});
		@(posedge ref_clk_i);
		idl <= 1'b1;
		@(posedge ref_clk_i);
		idl <= 1'b0;
		#1;
		chk("idle unlocked", 26'h0, {25'h0, peripheral_event_channel});
	endtask : t_idle
	task automatic t_map();
		chk("boot", 26'h1, {25'h0, ena});
		fk(24'h000100, 1'b1);
		fk(24'h008000, 1'b0);
		mw(1'b0, 1'b1, 1'b1);
		run(3'h1);
		fk(24'h000100, 1'b1);
		run(3'h1);
		chk("seg1 flag", 26'h1, {25'h0, s1o});
		fk(24'h000100, 1'b0);
		fk(24'h010100, 1'b1);
		dw(10'h005);
		mw(1'b1, 1'b0, 1'b0);
		run(3'h2);
		fk(24'h010100, 1'b1);
		jp(8'h01);
		fk(24'h010100, 1'b1);
		jp(8'h00);
		fk(24'h010100, 1'b0);
		mw(1'b1, 1'b0, 1'b1);
		run(3'h2);
		fk(24'h010100, 1'b1);
	endtask : t_map
	task automatic t_boot_ext();
		@(posedge ref_clk_i);
		bs <= 1'b0;
		nrst_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1;
		chk("ext boot", 26'h0, {25'h0, ena});
		chk("seg0 after reset", 26'h0, {25'h0, s1o});
		fk(24'h000100, 1'b0);
		mw(1'b1, 1'b0, 1'b1);
		run(3'h2);
		fk(24'h000100, 1'b1);
	endtask : t_boot_ext
	initial begin
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		t_addr();
		t_cmds();
		t_nest();
		t_idle();
		t_map();
		t_boot_ext();
		give_verdict();
	end
endmodule : address_override_rom_map_tb_top
bind address_override_rom_map aorm_monitor aorm_monitor_i (.ref_clk_i, .nrst_i, .ovr_req_i,
	.instr_done_i, .acc_req_i, .fetch_addr_i, .acc_rsp_o, .fetch_internal_o, .irq_block_o,
	.class_a_trap_block_o, .pec_block_o, .code_mem_enabled_o, .code_area_seg1_o);

// ### tb/aorm_monitor.sv
// port assertions for the address control block
`timescale 1ns/1ns
module aorm_monitor (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire addr_ctl_pkg::ovr_req_t ovr_req_i,
	input wire logic instr_done_i,
	input wire addr_ctl_pkg::acc_req_t acc_req_i,
	input wire logic [addr_ctl_pkg::ADDR_BITS-1:0] fetch_addr_i,
	input wire addr_ctl_pkg::acc_rsp_t acc_rsp_o,
	input wire logic fetch_internal_o,
	input wire logic irq_block_o,
	input wire logic class_a_trap_block_o,
	input wire logic pec_block_o,
	input wire logic code_mem_enabled_o,
	input wire logic code_area_seg1_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_take;
		ovr_req_i.valid && ovr_req_i.cmd != addr_ctl_pkg::OVR_NONE && ovr_req_i.count != 3'h0;
	endsequence
	sequence s_quiet;
		irq_block_o && !instr_done_i && !ovr_req_i.valid;
	endsequence
	property p_blk; s_take |=> irq_block_o; endproperty
	a_blk: assert property (p_blk) else $error("block late");
	property p_keep; s_quiet |=> irq_block_o; endproperty
	a_keep: assert property (p_keep) else $error("block lost");
	property p_trap; irq_block_o |-> class_a_trap_block_o; endproperty
	a_trap: assert property (p_trap) else $error("trap open");
	property p_pec; irq_block_o |-> pec_block_o; endproperty
	a_pec: assert property (p_pec) else $error("event open");
	property p_hold; !acc_req_i.valid |=> $stable(acc_rsp_o); endproperty
	a_hold: assert property (p_hold) else $error("rsp moved");
	property p_sfr; acc_req_i.valid && !acc_req_i.short_mode |=> !acc_rsp_o.to_ext_sfr; endproperty
	a_sfr: assert property (p_sfr) else $error("long redirected");
	property p_win;
		acc_rsp_o.to_internal |-> acc_rsp_o.addr[15] == 1'b0 && acc_rsp_o.addr[23:17] == 7'h00;
	endproperty
	a_win: assert property (p_win) else $error("window");
	property p_seg1;
		code_mem_enabled_o && code_area_seg1_o && fetch_addr_i[23:16] == 8'h00
			|-> !fetch_internal_o;
	endproperty
	a_seg1: assert property (p_seg1) else $error("seg 0 internal");
endmodule : aorm_monitor

// ### tb/pipe_model.sv
// pipeline model: one done pulse per instruction
`timescale 1ns/1ns
module pipe_model (
	input wire logic ref_clk_i,
	input wire logic start_i,
	input wire logic [2:0] n_i,
	output logic instr_done_o
);
	logic [2:0] left = 3'h0;
	always_ff @(posedge ref_clk_i) begin
		if (start_i) left <= n_i;
		else if (left != 3'h0) left <= left - 3'h1;
	end
	assign instr_done_o = left != 3'h0;
endmodule : pipe_model
